// ### rtl/fsk_out_pkg.sv
// constants shared by the fsk receiver serial output block
package fsk_out_pkg;
   // ---------------------------------------------------------------
   // line format
   // ---------------------------------------------------------------
   localparam int BAUD_RATE = 1200;
   localparam int DATA_BITS = 8;
   localparam int FIFO_DEPTH = 8;
   // ---------------------------------------------------------------
   // clock rates
   // ---------------------------------------------------------------
   localparam int LINK_CLK_HZ = 3579545;
   localparam int REF_PERIOD_NS = 4;
   // ---------------------------------------------------------------
   // times in their own units and derived cycle counts
   // ---------------------------------------------------------------
   localparam int HALF_BIT_US = 416;
   localparam int CD_HOLD_MS = 8;
   localparam int LINK_BIT_CYCLES = LINK_CLK_HZ / BAUD_RATE;
   localparam int HALF_BIT_CYCLES = (HALF_BIT_US * 1000) / REF_PERIOD_NS;
   localparam int CD_HOLD_CYCLES = (CD_HOLD_MS * 1000000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   // ---------------------------------------------------------------
   // idle level and word reset value
   // ---------------------------------------------------------------
   localparam logic IDLE_LEVEL = 1'b1;
   localparam logic [DATA_BITS-1:0] WORD_RESET = 8'h00;
endpackage : fsk_out_pkg

// ### rtl/sync2.sv
// two flip-flop synchroniser for single-bit levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta_r;
   // first stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= RESET_VAL;
         q_o <= RESET_VAL;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule : sync2
`default_nettype wire

// ### rtl/word_fifo.sv
// single-clock fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   wire [AW-1:0] wr_ptr_inc = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
   wire [AW-1:0] rd_ptr_inc = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
   // honest full and empty from the occupancy count
   assign in_ready_o = (count_r != (AW + 1)'(DEPTH)) && !flush_i;
   assign out_valid_o = (count_r != '0) && !flush_i;
   assign out_data_o = mem_r[rd_ptr_r];
   // storage array, no reset needed
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end
   // pointers and count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (flush_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_inc;
         if (pop) rd_ptr_r <= rd_ptr_inc;
         if (push && !pop) count_r <= count_r + 1'b1;
         else if (pop && !push) count_r <= count_r - 1'b1;
      end
   end
endmodule : word_fifo
`default_nettype wire

// ### rtl/fsk_serial_out.sv
// character receiver and three-wire serial output with carrier and sleep handling
`timescale 1ns/1ps
`default_nettype none
// Function
// R01: bit clock rises mid data cell
// R02: no bit clock on start, stop bits
// R03: one word ready pulse per character
// R04: controller latches byte on word ready
// R05: sleep request high enters power down
// R06: power down ignores line input entirely
// R07: sleep: data, clock high; open drains released
// R08: sleep request low resumes reception
// R09: carrier present low while tone detected
// R10: carrier present has time hysteresis
// R11: voice may drive outputs, no validation
// R12: controller ignores outputs when not expected
// R13: receive timing from single master oscillator
// R14: data mark high, idle high until carrier
// R15: exactly eight bit clock pulses per character
// R16: word ready low after last pulse
// R17: bit clock rests high between bursts
module fsk_serial_out
   import fsk_out_pkg::*;
#(
   parameter int LINK_BIT_CYC = fsk_out_pkg::LINK_BIT_CYCLES,
   parameter int HALF_BIT_CYC = fsk_out_pkg::HALF_BIT_CYCLES,
   parameter int CD_HOLD_CYC = fsk_out_pkg::CD_HOLD_CYCLES,
   parameter int DEPTH = fsk_out_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic link_clk_i,
   input wire logic demod_bit_i,
   input wire logic tone_present_i,
   input wire logic sleep_request_i,
   output logic data_o,
   output logic serial_bit_clock_o,
   output logic word_ready_n_o,
   output logic word_ready_n_oe_o,
   output logic carrier_present_n_o,
   output logic carrier_present_n_oe_o
);
   import fsk_out_pkg::*;

   // ---------------------------------------------------------------
   // reset release in both domains
   // ---------------------------------------------------------------
   localparam int LW = $clog2(LINK_BIT_CYC + 1);
   localparam int HW = $clog2(HALF_BIT_CYC + 1);
   localparam int CW = $clog2(CD_HOLD_CYC + 1);
   localparam logic [LW-1:0] L_BIT_LAST = LW'(LINK_BIT_CYC - 1);
   localparam logic [LW-1:0] L_HALF_LAST = LW'(LINK_BIT_CYC / 2 - 1);
   localparam logic [HW-1:0] H_HALF_LAST = HW'(HALF_BIT_CYC - 1);
   localparam logic [CW-1:0] C_HOLD_LAST = CW'(CD_HOLD_CYC - 1);
   localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
   logic rst_ref_n, rst_link_n;
   // ref domain reset copy
   sync2 #(.RESET_VAL(1'b0)) u_rst_ref (
      .clk_i(ref_clk_i),
      .rst_n_i(nrst_i),
      .d_i(1'b1),
      .q_o(rst_ref_n)
   );
   // link domain reset copy
   sync2 #(.RESET_VAL(1'b0)) u_rst_link (
      .clk_i(link_clk_i),
      .rst_n_i(nrst_i),
      .d_i(1'b1),
      .q_o(rst_link_n)
   );

   // ---------------------------------------------------------------
   // link domain: character receiver on the oscillator clock
   // ---------------------------------------------------------------
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
   rx_state_t rx_state_r, rx_state_nxt;
   logic [LW-1:0] rx_cnt_r, rx_cnt_nxt;
   logic [2:0] rx_idx_r, rx_idx_nxt;
   logic [DATA_BITS-1:0] rx_shift_r, rx_shift_nxt, link_word_r;
   logic req_tgl_r, ack_link, sleep_link;
   // sleep level into the link domain
   sync2 #(.RESET_VAL(1'b1)) u_sleep_link (
      .clk_i(link_clk_i),
      .rst_n_i(rst_link_n),
      .d_i(sleep_request_i),
      .q_o(sleep_link)
   );
   // acknowledge toggle back from the ref domain
   logic ack_tgl_r;
   sync2 #(.RESET_VAL(1'b0)) u_ack_link (
      .clk_i(link_clk_i),
      .rst_n_i(rst_link_n),
      .d_i(ack_tgl_r),
      .q_o(ack_link)
   );
   // a word is waiting for the ref side while the toggles differ
   wire link_pending = req_tgl_r != ack_link;
   wire rx_tick = rx_cnt_r == '0;
   wire stop_ok = demod_bit_i == IDLE_LEVEL;
   wire word_done = (rx_state_r == RX_STOP) && rx_tick && stop_ok && !link_pending && !sleep_link;
   // receiver next state; bit timing counts oscillator cycles
   always_comb begin
      rx_state_nxt = rx_state_r;
      rx_cnt_nxt = rx_tick ? '0 : rx_cnt_r - 1'b1; // [R13]
      rx_idx_nxt = rx_idx_r;
      rx_shift_nxt = rx_shift_r;
      case (rx_state_r)
         RX_IDLE: begin
            // any falling edge starts a character, tone or voice [R11]
            if (demod_bit_i != IDLE_LEVEL) begin
               rx_state_nxt = RX_START;
               rx_cnt_nxt = L_HALF_LAST;
            end
         end
         RX_START: begin
            if (rx_tick) begin
               if (demod_bit_i != IDLE_LEVEL) begin
                  rx_state_nxt = RX_DATA;
                  rx_cnt_nxt = L_BIT_LAST;
                  rx_idx_nxt = '0;
               end else begin
                  rx_state_nxt = RX_IDLE;
               end
            end
         end
         RX_DATA: begin
            if (rx_tick) begin
               rx_shift_nxt = {demod_bit_i, rx_shift_r[DATA_BITS-1:1]};
               rx_cnt_nxt = L_BIT_LAST;
               rx_idx_nxt = rx_idx_r + 1'b1;
               if (rx_idx_r == LAST_BIT) begin
                  rx_state_nxt = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            // a bad stop bit or a stalled handoff drops the character
            if (rx_tick) begin
               rx_state_nxt = RX_IDLE;
            end
         end
         default: begin
            rx_state_nxt = RX_IDLE;
         end
      endcase
      // power down holds the receiver idle and deaf [R06]
      if (sleep_link) begin
         rx_state_nxt = RX_IDLE;
         rx_cnt_nxt = '0;
      end
   end
   // receiver registers
   always_ff @(posedge link_clk_i or negedge rst_link_n) begin
      if (!rst_link_n) begin
         rx_state_r <= RX_IDLE;
         rx_cnt_r <= '0;
         rx_idx_r <= '0;
         rx_shift_r <= WORD_RESET;
      end else begin
         rx_state_r <= rx_state_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_idx_r <= rx_idx_nxt;
         rx_shift_r <= rx_shift_nxt;
      end
   end
   // hand a finished character to the ref domain, held until acknowledged
   always_ff @(posedge link_clk_i or negedge rst_link_n) begin
      if (!rst_link_n) begin
         link_word_r <= WORD_RESET;
         req_tgl_r <= 1'b0;
      end else if (word_done) begin
         link_word_r <= rx_shift_r;
         req_tgl_r <= ~req_tgl_r; // [R03]
      end
   end

   // ---------------------------------------------------------------
   // ref domain: pin synchronisers and word capture
   // ---------------------------------------------------------------
   logic sleep_ref, tone_ref, req_ref;
   // sleep request pin
   sync2 #(.RESET_VAL(1'b1)) u_sleep_ref (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_ref_n),
      .d_i(sleep_request_i),
      .q_o(sleep_ref)
   );
   // tone detect pin
   sync2 #(.RESET_VAL(1'b0)) u_tone_ref (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_ref_n),
      .d_i(tone_present_i),
      .q_o(tone_ref)
   );
   // request toggle from the link domain
   sync2 #(.RESET_VAL(1'b0)) u_req_ref (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_ref_n),
      .d_i(req_tgl_r),
      .q_o(req_ref)
   );
   logic carrier_r, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [DATA_BITS-1:0] fifo_out_data;
   // a word is offered while the toggles differ; link word is stable then
   wire word_offer = req_ref != ack_tgl_r;
   wire word_keep = carrier_r && !sleep_ref;
   wire fifo_push = word_offer && word_keep;
   wire word_take = word_offer && (!word_keep || fifo_in_ready);
   // acknowledge when the fifo accepts or when the word is dropped without carrier or in sleep, stalling the receiver otherwise
   always_ff @(posedge ref_clk_i or negedge rst_ref_n) begin
      if (!rst_ref_n) begin
         ack_tgl_r <= 1'b0;
      end else if (word_take) begin
         ack_tgl_r <= ~ack_tgl_r;
      end
   end

   // character buffer between receiver and serialiser
   word_fifo #(.WIDTH(DATA_BITS), .DEPTH(DEPTH)) u_fifo (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_ref_n),
      .flush_i(sleep_ref),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(link_word_r),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // ---------------------------------------------------------------
   // ref domain: carrier detect with time hysteresis
   // ---------------------------------------------------------------
   logic [CW-1:0] cd_cnt_r;
   wire cd_differs = tone_ref != carrier_r;
   wire cd_flip = cd_differs && (cd_cnt_r == C_HOLD_LAST);

   // state changes only after the tone has held its new level long enough
   always_ff @(posedge ref_clk_i or negedge rst_ref_n) begin
      if (!rst_ref_n) begin
         cd_cnt_r <= '0;
         carrier_r <= 1'b0;
      end else if (sleep_ref) begin
         cd_cnt_r <= '0;
         carrier_r <= 1'b0;
      end else begin
         cd_cnt_r <= (cd_differs && !cd_flip) ? cd_cnt_r + 1'b1 : '0; // [R10]
         if (cd_flip) carrier_r <= tone_ref; // [R09]
      end
   end

   // ---------------------------------------------------------------
   // ref domain: three-wire serialiser
   // ---------------------------------------------------------------
   typedef enum {TX_IDLE, TX_LOW, TX_HIGH, TX_READY} tx_state_t;
   tx_state_t tx_state_r, tx_state_nxt;
   logic [HW-1:0] tx_cnt_r, tx_cnt_nxt;
   logic [2:0] tx_idx_r, tx_idx_nxt;
   logic [DATA_BITS-1:0] tx_word_r, tx_word_nxt;
   logic data_r, data_nxt, clk_out_r, clk_out_nxt, ready_low_r, ready_low_nxt;
   wire tx_tick = tx_cnt_r == '0;
   assign fifo_out_ready = (tx_state_r == TX_IDLE) && !sleep_ref;
   // serialiser next state; only data bits get clock pulses [R02]
   always_comb begin
      tx_state_nxt = tx_state_r;
      tx_cnt_nxt = tx_tick ? '0 : tx_cnt_r - 1'b1;
      tx_idx_nxt = tx_idx_r;
      tx_word_nxt = tx_word_r;
      data_nxt = data_r;
      clk_out_nxt = clk_out_r;
      ready_low_nxt = ready_low_r;
      case (tx_state_r)
         TX_IDLE: begin
            clk_out_nxt = IDLE_LEVEL; // [R17]
            ready_low_nxt = 1'b0;
            // data idles high and only shows words taken while carrier is up
            data_nxt = IDLE_LEVEL; // [R14]
            if (fifo_out_valid) begin
               tx_state_nxt = TX_LOW;
               tx_cnt_nxt = H_HALF_LAST;
               tx_idx_nxt = '0;
               tx_word_nxt = fifo_out_data;
               data_nxt = fifo_out_data[0];
               clk_out_nxt = 1'b0;
            end
         end
         TX_LOW: begin
            // rising edge lands half a cell after the data change [R01]
            if (tx_tick) begin
               tx_state_nxt = TX_HIGH;
               tx_cnt_nxt = H_HALF_LAST;
               clk_out_nxt = 1'b1;
            end
         end
         TX_HIGH: begin
            if (tx_tick) begin
               tx_cnt_nxt = H_HALF_LAST;
               if (tx_idx_r == LAST_BIT) begin
                  // eight pulses done, mark the word boundary [R15]
                  tx_state_nxt = TX_READY;
                  ready_low_nxt = 1'b1; // [R16]
                  data_nxt = IDLE_LEVEL;
               end else begin
                  tx_state_nxt = TX_LOW;
                  tx_idx_nxt = tx_idx_r + 1'b1;
                  data_nxt = tx_word_r[tx_idx_r + 1'b1];
                  clk_out_nxt = 1'b0;
               end
            end
         end
         TX_READY: begin
            if (tx_tick) begin
               tx_state_nxt = TX_IDLE;
               ready_low_nxt = 1'b0;
            end
         end
         default: begin
            tx_state_nxt = TX_IDLE;
         end
      endcase
      // sleep forces data and clock high and stops all activity [R07]
      if (sleep_ref) begin
         tx_state_nxt = TX_IDLE;
         tx_cnt_nxt = '0;
         data_nxt = IDLE_LEVEL;
         clk_out_nxt = IDLE_LEVEL;
         ready_low_nxt = 1'b0;
      end
   end

   // serialiser registers
   always_ff @(posedge ref_clk_i or negedge rst_ref_n) begin
      if (!rst_ref_n) begin
         tx_state_r <= TX_IDLE;
         tx_cnt_r <= '0;
         tx_idx_r <= '0;
         tx_word_r <= WORD_RESET;
         data_r <= IDLE_LEVEL;
         clk_out_r <= IDLE_LEVEL;
         ready_low_r <= 1'b0;
      end else begin
         tx_state_r <= tx_state_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_idx_r <= tx_idx_nxt;
         tx_word_r <= tx_word_nxt;
         data_r <= data_nxt;
         clk_out_r <= clk_out_nxt;
         ready_low_r <= ready_low_nxt;
      end
   end

   // ---------------------------------------------------------------
   // pins; open drains pull low only while enabled
   // ---------------------------------------------------------------
   // reception resumes as soon as the synced sleep level drops [R08] [R05]
   assign data_o = data_r;
   assign serial_bit_clock_o = clk_out_r;
   assign word_ready_n_o = 1'b0;
   assign word_ready_n_oe_o = ready_low_r; // [R03]
   assign carrier_present_n_o = 1'b0;
   assign carrier_present_n_oe_o = carrier_r; // [R07]
endmodule : fsk_serial_out
`default_nettype wire

// ### dv/fsk_out_checker_assertions.sv
// concurrent checks on the pins of the fsk serial output block
`timescale 1ns/1ps
`default_nettype none
module fsk_out_checker #(
   parameter int HALF_BIT_CYC = 20,
   parameter int CD_HOLD_CYC = 50
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic tone_present_i,
   input wire logic sleep_request_i,
   input wire logic data_o,
   input wire logic serial_bit_clock_o,
   input wire logic word_ready_n_oe_o,
   input wire logic carrier_present_n_oe_o
);
   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   logic [5:0] slp_r;
   logic clk_d_r, wr_d_r;
   int lvl_r, wr_r, pul_r, hi_r, lo_r;
   wire quiet = (slp_r == 6'h00) && !sleep_request_i; // no sleep seen lately
   // level lengths, pulse count since last word ready, tone run lengths
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         slp_r <= 6'h3f;
         clk_d_r <= 1'b1;
         wr_d_r <= 1'b0;
         lvl_r <= 0;
         wr_r <= 0;
         pul_r <= 0;
         hi_r <= 0;
         lo_r <= 0;
      end else begin
         slp_r <= {slp_r[4:0], sleep_request_i};
         clk_d_r <= serial_bit_clock_o;
         wr_d_r <= word_ready_n_oe_o;
         lvl_r <= (serial_bit_clock_o != clk_d_r) ? 1 : lvl_r + 1;
         wr_r <= word_ready_n_oe_o ? wr_r + 1 : 0;
         pul_r <= (!quiet || (word_ready_n_oe_o && !wr_d_r)) ? 0 : pul_r + int'(serial_bit_clock_o && !clk_d_r);
         hi_r <= (!quiet || !tone_present_i) ? 0 : hi_r + 1;
         lo_r <= (!quiet || tone_present_i) ? 0 : lo_r + 1;
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   sequence sleep_held;
      sleep_request_i [*5];
   endsequence
   sequence burst_done;
      $rose(word_ready_n_oe_o);
   endsequence
   chk_sleep_idle: assert property (sleep_held |-> data_o && serial_bit_clock_o
      && !word_ready_n_oe_o && !carrier_present_n_oe_o) else $error("outputs not idle in sleep");
   chk_clock_low: assert property ($rose(serial_bit_clock_o) && quiet |-> lvl_r == HALF_BIT_CYC)
      else $error("bit clock low time wrong");
   chk_clock_high: assert property ($fell(serial_bit_clock_o) && quiet && pul_r != 0
      |-> lvl_r == HALF_BIT_CYC) else $error("bit clock high time wrong");
   chk_ready_width: assert property ($fell(word_ready_n_oe_o) && quiet |-> wr_r == HALF_BIT_CYC)
      else $error("word ready width wrong");
   chk_eight_pulses: assert property (burst_done |-> pul_r == 8)
      else $error("word ready not after eight pulses");
   chk_ready_idle: assert property (word_ready_n_oe_o |-> serial_bit_clock_o && data_o)
      else $error("bit clock or data active during word ready");
   chk_data_edge: assert property ($changed(data_o) && quiet |-> $fell(serial_bit_clock_o)
      || ($rose(word_ready_n_oe_o) && data_o)) else $error("data moved away from clock fall");
   chk_carrier_on: assert property ($rose(carrier_present_n_oe_o)
      |-> hi_r inside {[CD_HOLD_CYC-4:CD_HOLD_CYC+4]}) else $error("carrier set without hold time");
   chk_carrier_off: assert property ($fell(carrier_present_n_oe_o) && quiet
      |-> lo_r inside {[CD_HOLD_CYC-4:CD_HOLD_CYC+4]}) else $error("carrier cleared without hold time");
endmodule : fsk_out_checker
bind fsk_serial_out fsk_out_checker #(.HALF_BIT_CYC(HALF_BIT_CYC), .CD_HOLD_CYC(CD_HOLD_CYC)) chk_u (
   .ref_clk_i, .nrst_i, .tone_present_i, .sleep_request_i, .data_o, .serial_bit_clock_o,
   .word_ready_n_oe_o, .carrier_present_n_oe_o);
`default_nettype wire

// ### dv/ctrl_model.sv
// controller model that shifts in the serial word and collects it on word ready
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
   input wire logic rst_n_i,
   input wire logic sleep_i,
   input wire logic data_i,
   input wire logic sbc_i,
   input wire logic wr_pin_i,
   output logic [7:0] word_o,
   output int words_o,
   output int bits_o
);
   logic [7:0] sh_r;
   int cnt_r;
   initial begin
      word_o = 8'h00;
      words_o = 0;
      bits_o = 0;
      sh_r = 8'h00;
      cnt_r = 0;
   end
   // shift on each bit clock rise, lsb arrives first; nothing taken while powered down
   always @(posedge sbc_i) begin
      if (rst_n_i === 1'b1 && sleep_i === 1'b0) begin
         sh_r = {data_i, sh_r[7:1]};
         cnt_r = cnt_r + 1;
      end
   end
   // a partial burst cut by power down is thrown away
   always @(posedge sleep_i) begin
      cnt_r = 0;
   end
   // word ready low serves as the interrupt that collects the byte
   always @(negedge wr_pin_i) begin
      word_o = sh_r;
      bits_o = cnt_r;
      cnt_r = 0;
      words_o = words_o + 1;
   end
endmodule : ctrl_model
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the fsk serial output block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fsk_out_pkg::*;
   localparam int LB = 16;
   localparam int HB = 20;
   localparam int CH = 50;
   localparam int WW = 2 * HB * 9 + 60; // one whole burst plus handoff slack
   typedef struct {logic [7:0] din; logic tone; int n_exp;} row_t;
   logic ref_clk_i, link_clk_i, nrst_i, demod_bit_i, tone_present_i, sleep_request_i;
   logic data_o, serial_bit_clock_o, word_ready_n_o, word_ready_n_oe_o, carrier_present_n_o, carrier_present_n_oe_o;
   logic [7:0] got_word;
   int got_words, got_bits, failures, n_compared, n0;
   row_t rows [7] = '{'{8'h00, 1'b1, 1}, '{8'hff, 1'b1, 1}, '{8'ha5, 1'b1, 1}, '{8'h5a, 1'b1, 1},
      '{8'h01, 1'b1, 1}, '{8'h80, 1'b1, 1}, '{8'hc3, 1'b0, 0}};
   // open-drain pins with pull-ups
   wire wr_pin = word_ready_n_oe_o ? word_ready_n_o : 1'b1;
   wire cd_pin = carrier_present_n_oe_o ? carrier_present_n_o : 1'b1;
   fsk_serial_out #(.LINK_BIT_CYC(LB), .HALF_BIT_CYC(HB), .CD_HOLD_CYC(CH), .DEPTH(FIFO_DEPTH)) dut_u (
      .ref_clk_i, .nrst_i, .link_clk_i, .demod_bit_i, .tone_present_i, .sleep_request_i, .data_o,
      .serial_bit_clock_o, .word_ready_n_o, .word_ready_n_oe_o, .carrier_present_n_o, .carrier_present_n_oe_o);
   ctrl_model ctrl_u (.rst_n_i(nrst_i), .sleep_i(sleep_request_i), .data_i(data_o), .sbc_i(serial_bit_clock_o),
      .wr_pin_i(wr_pin), .word_o(got_word), .words_o(got_words), .bits_o(got_bits));
   // ---------------------------------------------------------------
   // clocks, the link clock unrelated in phase
   // ---------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #3;
      forever #16 link_clk_i = ~link_clk_i;
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp_bit
   task automatic cmp_word(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_word
   task automatic cmp_cnt(input string what, input int exp, input int got);
      n_compared++;
      if (got != exp) begin
         failures++;
         $display("FAIL %s expected %0d seen %0d", what, exp, got);
      end
   endtask : cmp_cnt
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   // one character: start, eight data bits lsb first, stop; line left at stop level
   task automatic send_char(input logic [7:0] b, input logic stop = 1'b1);
      logic [9:0] frame;
      frame = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge link_clk_i);
         demod_bit_i = frame[i];
         repeat (LB - 1) @(negedge link_clk_i);
      end
   endtask : send_char
   task automatic wait_ref(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : wait_ref
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      nrst_i = 1'b0;
      demod_bit_i = 1'b1;
      tone_present_i = 1'b0;
      sleep_request_i = 1'b0;
      failures = 0;
      n_compared = 0;
      wait_ref(4);
      cmp_bit("data_rst", 1'b1, data_o);
      cmp_bit("clock_rst", 1'b1, serial_bit_clock_o);
      cmp_bit("ready_rst", 1'b1, wr_pin);
      nrst_i = 1'b1;
      wait_ref(8);
      $display("test reset done");
      // ordinary characters, the last one without carrier
      foreach (rows[i]) begin
         tone_present_i = rows[i].tone;
         wait_ref(CH + 10);
         cmp_bit("carrier_pin", ~rows[i].tone, cd_pin);
         n0 = got_words;
         send_char(rows[i].din);
         wait_ref(WW);
         cmp_cnt("words", n0 + rows[i].n_exp, got_words);
         cmp_cnt("bits", 8, got_bits);
         cmp_word("word", rows[i].n_exp != 0 ? rows[i].din : rows[5].din, got_word);
         cmp_bit("data_idle", 1'b1, data_o);
      end
      $display("test table done");
      // back to back characters, then a start glitch shorter than half a bit
      tone_present_i = 1'b1;
      wait_ref(CH + 10);
      n0 = got_words;
      send_char(8'h3c);
      send_char(8'hc3);
      wait_ref(WW);
      cmp_cnt("words_b2b", n0 + 2, got_words);
      cmp_word("word_b2b", 8'hc3, got_word);
      @(negedge link_clk_i);
      demod_bit_i = 1'b0;
      repeat (LB / 4) @(negedge link_clk_i);
      demod_bit_i = 1'b1;
      wait_ref(WW);
      cmp_cnt("words_glitch", n0 + 2, got_words);
      // a character with a low stop bit is dropped
      send_char(8'h55, 1'b0);
      demod_bit_i = 1'b1;
      wait_ref(WW);
      cmp_cnt("words_badstop", n0 + 2, got_words);
      // carrier gap shorter than the hold time
      tone_present_i = 1'b0;
      wait_ref(CH / 2);
      tone_present_i = 1'b1;
      wait_ref(CH);
      cmp_bit("carrier_gap", 1'b0, cd_pin);
      $display("test awkward done");
      // power down in mid burst, line ignored, then wake
      n0 = got_words;
      send_char(8'h96);
      for (int k = 0; k < 3000 && serial_bit_clock_o !== 1'b0; k++) begin
         @(negedge ref_clk_i);
      end
      cmp_bit("burst_started", 1'b0, serial_bit_clock_o);
      wait_ref(HB);
      sleep_request_i = 1'b1;
      wait_ref(5);
      cmp_bit("data_sleep", 1'b1, data_o);
      cmp_bit("clock_sleep", 1'b1, serial_bit_clock_o);
      cmp_bit("ready_sleep", 1'b1, wr_pin);
      cmp_bit("carrier_sleep", 1'b1, cd_pin);
      send_char(8'h11);
      wait_ref(WW);
      cmp_cnt("words_sleep", n0, got_words);
      sleep_request_i = 1'b0;
      wait_ref(CH + 10);
      cmp_bit("carrier_wake", 1'b0, cd_pin);
      send_char(8'h69);
      wait_ref(WW);
      cmp_cnt("words_wake", n0 + 1, got_words);
      cmp_word("word_wake", 8'h69, got_word);
      cmp_cnt("bits_wake", 8, got_bits);
      $display("test sleep done");
      final_report();
   end
endmodule : tb
`default_nettype wire
